//--- rx_sys_pkg.sv
// Package: constants and types for the T1 receive system interface
`default_nettype none

package rx_sys_pkg;

    // ------------------------------------------------------------
    // Sizes and frame structure
    // ------------------------------------------------------------
    localparam int         NUM_FRAMERS    = 8;
    localparam int         NUM_BUSES      = 2;
    localparam logic [10:0] T1_FRAME_BITS  = 11'd193;
    localparam logic [10:0] MUX_FRAME_BITS = 11'd1024;
    localparam logic [4:0]  MULTIFRAME     = 5'd24;
    localparam logic [4:0]  SF_FRAMES      = 5'd12;
    localparam logic [6:0]  MUX_USED_SLOTS = 7'd96;

    // ------------------------------------------------------------
    // Master clock: half-bit ticks from a phase accumulator
    // ------------------------------------------------------------
    localparam int          CLOCK_KHZ       = 50000;
    localparam int          MASTER_RATE_KHZ = 1544;
    localparam logic [15:0] ACC_STEP        = 16'(2 * MASTER_RATE_KHZ);
    localparam logic [15:0] ACC_WRAP        = 16'(CLOCK_KHZ);

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SLAVE_EXT   = 2'h3;
    localparam logic [1:0] MODE_MASTER_FULL = 2'h1;
    localparam logic [1:0] MODE_MASTER_FRAC = 2'h0;
    localparam logic [1:0] RATE_T1          = 2'h0;
    localparam logic [1:0] RATE_MUX         = 2'h1;

    // ------------------------------------------------------------
    // Register map (framer n at n * 0x10)
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_OFFSET    = 12'h000;
    localparam logic [11:0] MASK_OFFSET   = 12'h004;
    localparam logic [11:0] FRAMER_SPAN   = 12'h080;
    localparam logic [11:0] STATUS_OFFSET = 12'h080;

    typedef struct packed {
        logic [6:0] channel_offset;
        logic       shared_bus_output_enable;
        logic       shared_bus_select;
        logic       master_clk_rise_sel;
        logic       common_clk_rise_sel;
        logic       frame_pulse_fall_sel;
        logic       double_rate_edge_sel;
        logic       double_rate_clock_sel;
        logic       frame_pulse_invert;
        logic       frame_pulse_option_b;
        logic       frame_pulse_option_a;
        logic       rate_sel_high;
        logic       rate_sel_low;
        logic [1:0] interface_mode_field;
    } cfg_t;

    localparam int          CFG_WIDTH  = $bits(cfg_t);
    localparam cfg_t        CFG_RESET  = '0;
    localparam logic [23:0] MASK_RESET = 24'h000000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       fbit;
        logic [4:0] ch;
        logic [2:0] idx;
    } pos_t;

    typedef struct packed {
        logic       fbit;
        logic [3:0] sig;
        logic [7:0] data;
    } payload_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [NUM_FRAMERS-1:0] data;
        logic [NUM_FRAMERS-1:0] fp;
        logic [NUM_FRAMERS-1:0] sig;
        logic [NUM_FRAMERS-1:0] clk;
    } framer_pins_t;

    typedef struct packed {
        logic [NUM_BUSES-1:0] data;
        logic [NUM_BUSES-1:0] fp;
        logic [NUM_BUSES-1:0] sig;
    } mux_pins_t;

endpackage

`default_nettype wire

//--- rx_sys_interface.sv
// Receive system interface of an eight-framer T1 device
//
// The address map and the APB register port were decided locally.
`default_nettype none
// Summary of operation
// - Slave: sample pulse, update outputs on chosen edges
// - Double rate, sample and update on same edge: update on first edge
// - Slave: shared pin carries aligned signaling bits
// - Master: own clock and pulse, 1.544 Mb/s
// - Master pulse: every, second, 12th, 24th frame
// - Master: outputs update on selected clock edge
// - Master full: continuous clock, all 24 channels
// - Master fractional: clock gapped where flag clear
// - Bit 1 of each channel goes first
// - Mux: two buses, select bit picks bus
// - Channel offset places framer data on bus
// - Bus enable decides whether framer drives bus
// - Mux: any edge-select one means all one
// - Mux: any double-rate bit one means all one
// - Double rate: edge-select picks update edge
// - Mux: sample and update on chosen edges
// - Mux frame pulse polarity set by invert bit
// - Mux pulse marks first selected framer only
// - Mux signaling aligned with mux data
// - Mode field and rate bits choose mode

module rx_sys_interface
    import rx_sys_pkg::*;
(
    // Clock and reset
    input  wire logic                               clock,
    input  wire logic                               srst,
    // Register bus
    input  wire apb_req_t                           apb_req,
    output var  apb_rsp_t                           apb_rsp,
    // Common clocks and frame pulses from the system
    input  wire logic                               rx_common_sys_clock,
    input  wire logic                               rx_common_frame_pulse,
    input  wire logic                               mux_common_clock,
    input  wire logic                               mux_common_frame_pulse,
    // Payload from the framers
    input  wire payload_t [NUM_FRAMERS-1:0]         payload,
    output var  logic     [NUM_FRAMERS-1:0][4:0]    payload_chan,
    // System side pins
    output var  framer_pins_t                       framer_pins,
    output var  mux_pins_t                          mux_pins
);

    typedef struct packed {
        cfg_t [NUM_FRAMERS-1:0]        cfg;
        logic [NUM_FRAMERS-1:0][23:0]  mask;
        logic [2:0]                    cclk_s;
        logic [1:0]                    cfp_s;
        logic [2:0]                    mclk_s;
        logic [1:0]                    mfp_s;
        logic [10:0]                   c_bit;
        logic [4:0]                    c_frame;
        logic                          c_phase;
        logic [15:0]                   acc;
        logic                          m_half;
        logic [10:0]                   m_bit;
        logic [4:0]                    m_frame;
        logic [NUM_FRAMERS-1:0][4:0]   chan;
        framer_pins_t                  pins;
        mux_pins_t                     mux;
        apb_rsp_t                      rsp;
    } state_t;

    state_t                 st_q;
    state_t                 st_d;
    logic                   mux_on;
    logic                   upd;
    logic                   special;
    logic                   tick;
    logic                   m_rise;
    logic                   m_fall;
    logic                   slave0;
    logic                   master0;
    logic [NUM_FRAMERS-1:0] gapped;
    cfg_t                   eff;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic pos_t locate(input logic [10:0] bitn, input logic mux,
                                    input logic [6:0] off);
        pos_t        p;
        logic [6:0]  rel;
        logic [10:0] t1;
        p   = '0;
        rel = 7'(bitn[9:3] - off);
        t1  = 11'(bitn - 11'd1);
        if (mux) begin
            // Four framers interleave one byte each per group of slots
            p.valid = (rel[1:0] == 2'd0) && (rel < MUX_USED_SLOTS);
            p.ch    = rel[6:2];
            p.idx   = bitn[2:0];
        end else if (bitn == 11'd0) begin
            p.fbit = 1'b1;
        end else begin
            p.valid = 1'b1;
            p.ch    = t1[7:3];
            p.idx   = t1[2:0];
        end
        return p;
    endfunction

    // Returns {data bit, signaling bit}
    function automatic logic [1:0] bit_value(input payload_t pl, input pos_t p);
        logic dat;
        logic sig;
        dat = p.fbit ? pl.fbit : (p.valid ? pl.data[3'd7 - p.idx] : 1'b0);
        sig = (p.valid && p.idx[2]) ? pl.sig[2'd3 - p.idx[1:0]] : 1'b0;
        return {dat, sig};
    endfunction

    function automatic logic fp_mark(input cfg_t c, input logic [4:0] frame,
                                     input logic fbit);
        logic m;
        case ({c.frame_pulse_option_a, c.frame_pulse_option_b})
            2'b00:   m = fbit;
            2'b01:   m = fbit && !frame[0];
            2'b10:   m = fbit && (frame == 5'd0 || frame == SF_FRAMES);
            default: m = fbit && (frame == 5'd0);
        endcase
        return m ^ c.frame_pulse_invert;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_t      q;
        state_t      d;
        cfg_t        c;
        pos_t        ps;
        pos_t        pm;
        pos_t        pmd;
        pos_t        px;
        logic [1:0]  bv;
        logic [1:0]  mdat;
        logic [1:0]  msig;
        logic [1:0]  mfp;
        logic [1:0]  first;
        logic        clk_lvl;
        logic        clk_old;
        logic        fp_lvl;
        logic        rise_e;
        logic        fall_e;
        logic        smp_e;
        logic        pol_e;
        logic        fp_hit;
        logic        is_slave;
        logic        is_master;
        logic [10:0] flen;
        logic [16:0] sum;
        logic [31:0] rd;
        logic        hit;
        logic [2:0]  idx;
        q = st_q;
        d = st_q;
        c = '0;
        ps = '0;
        pm = '0;
        pmd = '0;
        px = '0;
        bv = '0;
        mdat = '0;
        msig = '0;
        mfp = '0;
        first = '0;
        rd = '0;
        clk_lvl = 1'b0;
        clk_old = 1'b0;
        fp_lvl = 1'b0;
        rise_e = 1'b0;
        fall_e = 1'b0;
        smp_e = 1'b0;
        pol_e = 1'b0;
        fp_hit = 1'b0;
        is_slave = 1'b0;
        is_master = 1'b0;
        flen = '0;
        sum = '0;
        hit = 1'b0;
        idx = apb_req.paddr[6:4];
        gapped = '0;
        slave0 = 1'b0;
        master0 = 1'b0;

        // Synchronisers; only stage 1 and 2 are read by logic
        d.cclk_s = {q.cclk_s[1:0], rx_common_sys_clock};
        d.cfp_s  = {q.cfp_s[0], rx_common_frame_pulse};
        d.mclk_s = {q.mclk_s[1:0], mux_common_clock};
        d.mfp_s  = {q.mfp_s[0], mux_common_frame_pulse};

        mux_on = 1'b0;
        for (int n = 0; n < NUM_FRAMERS; n++) begin
            if ({q.cfg[n].rate_sel_low, q.cfg[n].rate_sel_high} == RATE_MUX) begin
                mux_on = 1'b1;
            end
        end

        // Edge settings: framer 0 governs the common pulse in slave mode
        eff = q.cfg[0];
        if (mux_on) begin
            for (int n = 0; n < NUM_FRAMERS; n++) begin
                eff.frame_pulse_fall_sel  |= q.cfg[n].frame_pulse_fall_sel;
                eff.common_clk_rise_sel   |= q.cfg[n].common_clk_rise_sel;
                eff.double_rate_clock_sel |= q.cfg[n].double_rate_clock_sel;
                eff.double_rate_edge_sel  |= q.cfg[n].double_rate_edge_sel;
            end
        end

        // ------------------------------------------------------------
        // Common clock engine (slave and multiplexed)
        // ------------------------------------------------------------
        clk_lvl = mux_on ? q.mclk_s[1] : q.cclk_s[1];
        clk_old = mux_on ? q.mclk_s[2] : q.cclk_s[2];
        fp_lvl  = mux_on ? q.mfp_s[1] : q.cfp_s[1];
        rise_e  = clk_lvl & ~clk_old;
        fall_e  = ~clk_lvl & clk_old;
        smp_e   = eff.frame_pulse_fall_sel ? fall_e : rise_e;
        pol_e   = eff.common_clk_rise_sel ? rise_e : fall_e;
        special = eff.double_rate_clock_sel &&
                  (eff.frame_pulse_fall_sel != eff.common_clk_rise_sel);
        upd     = pol_e && (!eff.double_rate_clock_sel ||
                  q.c_phase == (eff.double_rate_edge_sel && !special));
        // Pulse is only taken on the first edge of a bit at double rate
        fp_hit  = smp_e && (fp_lvl ^ eff.frame_pulse_invert) &&
                  (!eff.double_rate_clock_sel || !q.c_phase);
        flen    = mux_on ? MUX_FRAME_BITS : T1_FRAME_BITS;

        if (fp_hit) begin
            d.c_bit   = '0;
            d.c_phase = 1'b0;
        end else if (pol_e) begin
            d.c_phase = ~q.c_phase;
            if (upd) begin
                if (q.c_bit == 11'(flen - 11'd1)) begin
                    d.c_bit   = '0;
                    d.c_frame = (q.c_frame == 5'(MULTIFRAME - 5'd1)) ? 5'd0
                                                                      : 5'(q.c_frame + 5'd1);
                end else begin
                    d.c_bit = 11'(q.c_bit + 11'd1);
                end
            end
        end

        // ------------------------------------------------------------
        // Master engine: 1.544 MHz on average, one cycle of jitter
        // ------------------------------------------------------------
        sum  = {1'b0, q.acc} + {1'b0, ACC_STEP};
        tick = (sum >= {1'b0, ACC_WRAP});
        d.acc = tick ? 16'(sum - {1'b0, ACC_WRAP}) : sum[15:0];
        m_rise = tick && !q.m_half;
        m_fall = tick && q.m_half;
        if (tick) begin
            d.m_half = ~q.m_half;
        end
        if (m_rise) begin
            if (q.m_bit == 11'(T1_FRAME_BITS - 11'd1)) begin
                d.m_bit   = '0;
                d.m_frame = (q.m_frame == 5'(MULTIFRAME - 5'd1)) ? 5'd0
                                                                  : 5'(q.m_frame + 5'd1);
            end else begin
                d.m_bit = 11'(q.m_bit + 11'd1);
            end
        end
        pm  = locate(q.m_bit, 1'b0, 7'd0);
        pmd = locate(d.m_bit, 1'b0, 7'd0);
        ps  = locate(q.c_bit, 1'b0, 7'd0);

        // ------------------------------------------------------------
        // Per-framer pins and multiplexed buses
        // ------------------------------------------------------------
        for (int n = 0; n < NUM_FRAMERS; n++) begin
            c = q.cfg[n];
            is_slave  = !mux_on && c.interface_mode_field == MODE_SLAVE_EXT &&
                        {c.rate_sel_low, c.rate_sel_high} == RATE_T1;
            is_master = (c.interface_mode_field == MODE_MASTER_FULL ||
                         c.interface_mode_field == MODE_MASTER_FRAC) &&
                        {c.rate_sel_low, c.rate_sel_high} == RATE_T1;
            if (n == 0) begin
                slave0  = is_slave;
                master0 = is_master;
            end
            if (is_slave) begin
                d.chan[n]       = ps.ch;
                d.pins.clk[n]   = 1'b0;
                if (upd) begin
                    bv = bit_value(payload[n], ps);
                    d.pins.data[n] = bv[1];
                    d.pins.sig[n]  = bv[0];
                    d.pins.fp[n]   = fp_mark(c, q.c_frame, ps.fbit);
                end
            end else if (is_master) begin
                d.chan[n] = pm.ch;
                gapped[n] = c.interface_mode_field == MODE_MASTER_FRAC && pmd.valid &&
                            !q.mask[n][pmd.ch];
                d.pins.clk[n] = gapped[n] ? 1'b0 : d.m_half;
                d.pins.sig[n] = 1'b0;
                if (c.master_clk_rise_sel ? m_rise : m_fall) begin
                    bv = bit_value(payload[n], pm);
                    d.pins.data[n] = bv[1];
                    d.pins.fp[n]   = fp_mark(c, q.m_frame, pm.fbit);
                end
            end else begin
                d.pins.data[n] = 1'b0;
                d.pins.sig[n]  = 1'b0;
                d.pins.fp[n]   = 1'b0;
                d.pins.clk[n]  = 1'b0;
            end

            if (mux_on && c.interface_mode_field == MODE_SLAVE_EXT &&
                c.shared_bus_output_enable) begin
                px = locate(q.c_bit, 1'b1, c.channel_offset);
                d.chan[n] = px.ch;
                bv = bit_value(payload[n], px);
                if (px.valid) begin
                    mdat[c.shared_bus_select] = mdat[c.shared_bus_select] | bv[1];
                    msig[c.shared_bus_select] = msig[c.shared_bus_select] | bv[0];
                end
                if (!first[c.shared_bus_select]) begin
                    first[c.shared_bus_select] = 1'b1;
                    mfp[c.shared_bus_select]   = (q.c_bit == 11'd0);
                end
            end
        end

        if (!mux_on) begin
            d.mux = '0;
        end else if (upd) begin
            d.mux.data = mdat;
            d.mux.sig  = msig;
            d.mux.fp   = mfp ^ {NUM_BUSES{eff.frame_pulse_invert}};
        end

        // ------------------------------------------------------------
        // APB slave: one wait state, write lands when pready is seen
        // ------------------------------------------------------------
        if (apb_req.paddr < FRAMER_SPAN) begin
            if (apb_req.paddr[3:0] == CFG_OFFSET[3:0]) begin
                hit = 1'b1;
                rd  = 32'(q.cfg[idx]);
            end else if (apb_req.paddr[3:0] == MASK_OFFSET[3:0]) begin
                hit = 1'b1;
                rd  = 32'(q.mask[idx]);
            end
        end else if (apb_req.paddr == STATUS_OFFSET) begin
            hit = 1'b1;
            rd  = {2'h0, mux_on, q.c_frame, q.c_bit, q.m_frame, q.m_bit[7:0]};
        end

        if (apb_req.psel && apb_req.penable) begin
            if (!q.rsp.pready) begin
                d.rsp.pready  = 1'b1;
                d.rsp.prdata  = apb_req.pwrite ? 32'h00000000 : rd;
                d.rsp.pslverr = !hit;
            end else begin
                d.rsp.pready = 1'b0;
                if (apb_req.pwrite && hit && apb_req.paddr < FRAMER_SPAN) begin
                    if (apb_req.paddr[3:0] == CFG_OFFSET[3:0]) begin
                        d.cfg[idx] = cfg_t'(apb_req.pwdata[CFG_WIDTH-1:0]);
                    end else begin
                        d.mask[idx] = apb_req.pwdata[23:0];
                    end
                end
            end
        end else begin
            d.rsp.pready  = 1'b0;
            d.rsp.pslverr = 1'b0;
        end

        st_d = d;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q      <= '0;
            st_q.cfg  <= {NUM_FRAMERS{CFG_RESET}};
            st_q.mask <= {NUM_FRAMERS{MASK_RESET}};
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp      = st_q.rsp;
    assign payload_chan = st_q.chan;
    assign framer_pins  = st_q.pins;
    assign mux_pins     = st_q.mux;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [7:0] tick_gap_q;
    logic       tick_seen_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            tick_gap_q  <= 8'h00;
            tick_seen_q <= 1'b0;
        end else if (tick) begin
            tick_gap_q  <= 8'h00;
            tick_seen_q <= 1'b1;
        end else begin
            tick_gap_q <= 8'(tick_gap_q + 8'h01);
        end
    end

    a_slave_data_edge: assert property (
        @(posedge clock) disable iff (srst)
        $past(slave0) && st_q.pins.data[0] != $past(st_q.pins.data[0]) |-> $past(upd))
        else $error("slave data changed away from an update edge");

    a_special_first_edge: assert property (
        @(posedge clock) disable iff (srst)
        upd && special |-> !st_q.c_phase)
        else $error("special case update not on first edge");

    a_sig_no_clock: assert property (
        @(posedge clock) disable iff (srst)
        slave0 |=> !st_q.pins.clk[0])
        else $error("slave framer drove a clock on the signaling pin");

    a_master_tick_rate: assert property (
        @(posedge clock) disable iff (srst)
        tick && tick_seen_q |-> tick_gap_q inside {8'd15, 8'd16})
        else $error("master half-bit tick spacing wrong");

    a_slave_fp_every: assert property (
        @(posedge clock) disable iff (srst)
        slave0 && upd && !st_q.cfg[0].frame_pulse_option_a &&
        !st_q.cfg[0].frame_pulse_option_b |=>
        st_q.pins.fp[0] == (($past(st_q.c_bit) == 11'd0) ^ $past(st_q.cfg[0].frame_pulse_invert)))
        else $error("slave frame pulse not on F-bit");

    a_master_data_edge: assert property (
        @(posedge clock) disable iff (srst)
        $past(master0) && st_q.pins.data[0] != $past(st_q.pins.data[0]) |->
        $past(st_q.cfg[0].master_clk_rise_sel ? m_rise : m_fall))
        else $error("master data changed off the selected edge");

    a_frac_clock_gap: assert property (
        @(posedge clock) disable iff (srst)
        master0 && gapped[0] |=> !st_q.pins.clk[0])
        else $error("gapped channel still clocked");

    a_mux_edge_merge: assert property (
        @(posedge clock) disable iff (srst)
        mux_on && st_q.cfg[7].common_clk_rise_sel |-> eff.common_clk_rise_sel)
        else $error("mux edge select not merged");

endmodule

`default_nettype wire

//--- sys_partner.sv
// Backplane model: free common clock, frame pulse, framer 0 capture
`default_nettype none
module sys_partner (
    // Link side
    output var  logic       lclk,
    output var  logic       fpulse,
    input  wire logic       din,
    input  wire logic       sin,
    input  wire logic       fin,
    // Observation
    input  wire logic       rise,
    output var  logic [7:0] cnt,
    output var  logic [8:0] dh,
    output var  logic [8:0] sh,
    output var  logic [8:0] fh
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] bit_q = 8'h00;
    always #80 lclk = (lclk === 1'b1) ? 1'b0 : 1'b1;
    always @(negedge lclk) begin
        bit_q  <= (bit_q === 8'd192) ? 8'd0 : bit_q + 8'd1;
        fpulse <= (bit_q === 8'd192);
    end
    always @(posedge lclk) begin
        cnt <= fpulse ? 8'h00 : cnt + 8'h01;
    end
    // Capture on the update edge, a full period after each update settles
    always @(lclk) begin
        if (lclk === rise) begin
            dh <= {dh[7:0], din};
            sh <= {sh[7:0], sin};
            fh <= {fh[7:0], fin};
        end
    end
endmodule
`default_nettype wire

//--- rx_sys_interface_tb.sv
// Testbench: register access and slave-mode serial stream checks
`default_nettype none
module rx_sys_interface_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rx_sys_pkg::*;
    logic                       clock = 1'b0;
    logic                       srst = 1'b1;
    logic                       rise = 1'b0;
    apb_req_t                   req = '0;
    apb_rsp_t                   rsp;
    payload_t [NUM_FRAMERS-1:0] pay = {NUM_FRAMERS{13'h1ab4}};
    framer_pins_t               fpins;
    logic                       lclk;
    logic                       fpulse;
    logic [7:0]                 cnt;
    logic [8:0]                 dh;
    logic [8:0]                 sh;
    logic [8:0]                 fh;
    logic [31:0]                rd;
    logic                       err;
    int                         bad_count = 0;
    int                         total_checks = 0;
    always #10 clock = ~clock;
    rx_sys_interface DUT (.clock(clock), .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .rx_common_sys_clock(lclk), .rx_common_frame_pulse(fpulse),
        .mux_common_clock(1'b0), .mux_common_frame_pulse(1'b0), .payload(pay),
        .payload_chan(), .framer_pins(fpins), .mux_pins());
    sys_partner far (.lclk(lclk), .fpulse(fpulse), .din(fpins.data[0]),
        .sin(fpins.sig[0]), .fin(fpins.fp[0]), .rise(rise), .cnt(cnt),
        .dh(dh), .sh(sh), .fh(fh));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Edge first, so a new setup never lands on the release of the last one
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        do @(posedge clock); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic wt(input logic [7:0] c);
        do @(posedge clock); while (cnt !== c);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h004, 32'hffffffff);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h00ffffff);
        apb(1'b0, 12'h0f0, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        for (int r = 0; r < 2; r++) begin
            rise <= r[0];
            for (int f = 0; f < 8; f++)
                apb(1'b1, 12'(f * 16), r ? 32'h403 : 32'h003);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, r ? 32'h403 : 32'h003);
            wt(8'd20);
            wt(8'd10);
            chk({23'h0, dh}, 32'h1b4);
            chk({24'h0, dh[7:0]}, 32'hb4);
            chk({24'h0, sh[7:0]}, 32'h0a);
            chk({23'h0, fh}, 32'h100);
        end
        close_out();
    end
    initial begin
        #400000;
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire
